// file: hdl/ptmr_top.sv
// Periodic 10-bit timer with two comparators behind an AHB-Lite register slave
`timescale 1ns/1ps
module ptmr_top (
   // System
   input wire logic CLK_SYS,
   input wire logic RST_B,
   // Internal clock strobes, one system cycle wide
   input wire logic HIGH_CLK_STB,
   input wire logic TBC_CLK_STB,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic HREADY,
   input wire logic [31:0] HWDATA,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Pins
   input wire logic EXT_CLOCK_PIN,
   input wire logic TIMER_IO_PIN_I,
   output logic TIMER_IO_PIN_O,
   output logic TIMER_IO_PIN_OE,
   // Events and compare-mode output hooks
   output logic MATCH_A_EVT,
   output logic MATCH_P_EVT,
   output logic CAPTURE_EVT
);
   import ptmr_pkg::*;
   localparam int W = PTMR_CNT_W;

   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [W-1:0] cnt;
      logic [W-1:0] cmp_a;
      logic [W-1:0] cmp_p;
      logic run_prev;
      logic out_lvl;
      logic evt_a;
      logic evt_p;
      logic evt_cap;
      logic flag_a;
      logic flag_p;
      logic flag_cap;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
   } ptmr_state_type;
   ptmr_state_type st_q, st_d;

   logic ext_rise, ext_fall, io_rise, io_fall;
   logic sys4_tick, h16_tick, h64_tick;
   logic tick, run, pause, ovf, match_a, match_p, do_clear, cap_trig;
   logic [2:0] cksel;
   logic [1:0] mode, iof;
   logic rd_req;
   logic [7:0] rd_addr;
   logic [31:0] rd_val;

   ptmr_edge u_ext_edge (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .pin(EXT_CLOCK_PIN),
      .rise(ext_rise),
      .fall(ext_fall)
   );
   ptmr_edge u_io_edge (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .pin(TIMER_IO_PIN_I),
      .rise(io_rise),
      .fall(io_fall)
   );
   ptmr_tick #(.DIV(PTMR_DIV_SYS)) u_div_sys (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .src(1'b1),
      .tick(sys4_tick)
   );
   ptmr_tick #(.DIV(PTMR_DIV_H16)) u_div_h16 (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .src(HIGH_CLK_STB),
      .tick(h16_tick)
   );
   ptmr_tick #(.DIV(PTMR_DIV_H64)) u_div_h64 (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .src(HIGH_CLK_STB),
      .tick(h64_tick)
   );

   assign pause = st_q.ctrl_a[PTMR_PAUSE_BIT];
   assign run = st_q.ctrl_a[PTMR_RUN_BIT];
   assign cksel = st_q.ctrl_a[PTMR_CKSEL_LSB +: 3];
   assign mode = st_q.ctrl_b[PTMR_MODE_LSB +: 2];
   assign iof = st_q.ctrl_b[PTMR_IOF_LSB +: 2];

   // Clock source select; external edges come through the synchroniser
   always_comb begin
      case (cksel)
         PTMR_CK_SYS4: tick = sys4_tick;
         PTMR_CK_SYS: tick = 1'b1;
         PTMR_CK_H16: tick = h16_tick;
         PTMR_CK_H64: tick = h64_tick;
         PTMR_CK_TBC: tick = TBC_CLK_STB;
         PTMR_CK_H: tick = HIGH_CLK_STB;
         PTMR_CK_EXTR: tick = ext_rise;
         PTMR_CK_EXTF: tick = ext_fall;
         default: tick = 1'b0;
      endcase
   end

   assign match_a = (st_q.cnt == st_q.cmp_a);
   assign match_p = (st_q.cnt == st_q.cmp_p);
   assign ovf = (st_q.cnt == {W{1'b1}});

   // Clear source; capture mode always clears on P
   always_comb begin
      // A zero P value means a full period; clearing on its match would pin the count at zero
      if (mode == PTMR_MODE_CAP) begin
         do_clear = (st_q.cmp_p == '0) ? ovf : match_p;
      end else if (st_q.ctrl_b[PTMR_CLRS_BIT] && mode != PTMR_MODE_PWM) begin
         do_clear = match_a;
      end else begin
         do_clear = (st_q.cmp_p == '0) ? ovf : match_p;
      end
   end

   // Capture trigger from selected pin and edge field
   always_comb begin
      logic r, f;
      r = st_q.ctrl_b[PTMR_CAPS_BIT] ? ext_rise : io_rise;
      f = st_q.ctrl_b[PTMR_CAPS_BIT] ? ext_fall : io_fall;
      case (iof)
         2'h0: cap_trig = r;
         2'h1: cap_trig = f;
         2'h2: cap_trig = r | f;
         default: cap_trig = 1'b0;
      endcase
      cap_trig = cap_trig && run && (mode == PTMR_MODE_CAP);
   end

   assign rd_req = HSEL && HREADY && HTRANS[1] && !HWRITE;
   assign rd_addr = HADDR[7:0];

   always_comb begin
      case (rd_addr)
         PTMR_OFF_CTRL_A: rd_val = {24'h000000, st_q.ctrl_a & PTMR_CTRL_A_MASK};
         PTMR_OFF_CTRL_B: rd_val = {24'h000000, st_q.ctrl_b};
         PTMR_OFF_CNT_LO: rd_val = {24'h000000, st_q.cnt[7:0]};
         PTMR_OFF_CNT_HI: rd_val = {30'h00000000, st_q.cnt[W-1:8]};
         PTMR_OFF_CMPA_LO: rd_val = {24'h000000, st_q.cmp_a[7:0]};
         PTMR_OFF_CMPA_HI: rd_val = {30'h00000000, st_q.cmp_a[W-1:8]};
         PTMR_OFF_CMPP_LO: rd_val = {24'h000000, st_q.cmp_p[7:0]};
         PTMR_OFF_CMPP_HI: rd_val = {30'h00000000, st_q.cmp_p[W-1:8]};
         PTMR_OFF_STATUS: rd_val = {29'h00000000, st_q.flag_cap, st_q.flag_p, st_q.flag_a};
         default: rd_val = 32'h00000000;
      endcase
   end

   always_comb begin
      st_d = st_q;
      st_d.evt_a = 1'b0;
      st_d.evt_p = 1'b0;
      st_d.evt_cap = 1'b0;
      st_d.run_prev = run;
      // Register writes land in the data phase
      st_d.wr_pend = HSEL && HREADY && HTRANS[1] && HWRITE;
      if (st_d.wr_pend) begin
         st_d.wr_addr = HADDR[7:0];
      end
      if (rd_req) begin
         st_d.rdata = rd_val;
      end
      if (st_q.wr_pend) begin
         case (st_q.wr_addr)
            PTMR_OFF_CTRL_A: st_d.ctrl_a = HWDATA[7:0] & PTMR_CTRL_A_MASK;
            PTMR_OFF_CTRL_B: st_d.ctrl_b = HWDATA[7:0];
            PTMR_OFF_CMPA_LO: st_d.cmp_a[7:0] = HWDATA[7:0];
            PTMR_OFF_CMPA_HI: st_d.cmp_a[W-1:8] = HWDATA[1:0];
            PTMR_OFF_CMPP_LO: st_d.cmp_p[7:0] = HWDATA[7:0];
            PTMR_OFF_CMPP_HI: st_d.cmp_p[W-1:8] = HWDATA[1:0];
            // Write one to clear; a new event in the same cycle wins below
            PTMR_OFF_STATUS: begin
               st_d.flag_a = st_q.flag_a & ~HWDATA[0];
               st_d.flag_p = st_q.flag_p & ~HWDATA[1];
               st_d.flag_cap = st_q.flag_cap & ~HWDATA[2];
            end
            default: ;
         endcase
      end
      // Counter: no software load path exists; a run rising edge or the selected clear source zeroes it
      if (run && !st_q.run_prev) begin
         st_d.cnt = '0;
         st_d.out_lvl = st_q.ctrl_b[PTMR_OLVL_BIT];
      end else if (run && !pause && tick) begin
         st_d.evt_a = match_a;
         st_d.evt_p = match_p && !(st_q.ctrl_b[PTMR_CLRS_BIT] && mode != PTMR_MODE_CAP);
         if (do_clear) begin
            st_d.cnt = '0;
         end else begin
            st_d.cnt = W'(st_q.cnt + 1'b1);
         end
         if (match_a && mode == PTMR_MODE_CMP) begin
            case (iof)
               2'h1: st_d.out_lvl = 1'b0;
               2'h2: st_d.out_lvl = 1'b1;
               2'h3: st_d.out_lvl = ~st_q.out_lvl;
               default: ;
            endcase
         end
      end
      if (cap_trig) begin
         st_d.cmp_a = st_q.cnt;
         st_d.evt_cap = 1'b1;
      end
      if (st_d.evt_a) begin
         st_d.flag_a = 1'b1;
      end
      if (st_d.evt_p) begin
         st_d.flag_p = 1'b1;
      end
      if (st_d.evt_cap) begin
         st_d.flag_cap = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign HRDATA = st_q.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign MATCH_A_EVT = st_q.evt_a;
   assign MATCH_P_EVT = st_q.evt_p;
   assign CAPTURE_EVT = st_q.evt_cap;
   // Mode decode; PWM and single pulse waveforms are not built here, pin only tracks level
   assign TIMER_IO_PIN_OE = run && (mode == PTMR_MODE_CMP || mode == PTMR_MODE_PWM);
   assign TIMER_IO_PIN_O = TIMER_IO_PIN_OE && (st_q.out_lvl ^ st_q.ctrl_b[PTMR_INV_BIT]);

   run_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      $rose(run) |=> st_q.cnt == '0) else $error("counter not cleared on run");
   hold_stop_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (!run && !st_q.run_prev) |=> $stable(st_q.cnt)) else $error("counter moved while stopped");
   hold_pause_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (pause && run && st_q.run_prev && !cap_trig) |=> st_q.cnt == $past(st_q.cnt))
      else $error("counter moved while paused");
   count_up_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (run && st_q.run_prev && !pause && tick && !do_clear) |=> st_q.cnt == W'($past(st_q.cnt) + 1'b1))
      else $error("counter did not advance");
   clear_match_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (run && st_q.run_prev && !pause && tick && do_clear) |=> st_q.cnt == '0)
      else $error("counter not cleared on match");
   pin_free_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      mode == PTMR_MODE_TMR |-> !TIMER_IO_PIN_OE) else $error("pin driven in timer mode");
   init_lvl_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      ($rose(run) && mode == PTMR_MODE_CMP) |=> st_q.out_lvl == $past(st_q.ctrl_b[PTMR_OLVL_BIT]))
      else $error("initial level not loaded");
   flag_a_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      st_q.evt_a |-> st_q.flag_a) else $error("match flag lost");
   hi_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (rd_req && rd_addr == PTMR_OFF_CNT_HI) |=> HRDATA[31:2] == '0) else $error("high bits not zero");

   run_c: cover property (@(posedge CLK_SYS) disable iff (!RST_B) $rose(run));
   match_c: cover property (@(posedge CLK_SYS) disable iff (!RST_B) st_q.evt_a);
   ovf_c: cover property (@(posedge CLK_SYS) disable iff (!RST_B) run && tick && ovf);
   cap_c: cover property (@(posedge CLK_SYS) disable iff (!RST_B) st_q.evt_cap);
endmodule

// file: hdl/ptmr_pkg.sv
// Package with register map, field positions and clock codes of the periodic timer
package ptmr_pkg;
   localparam int PTMR_CNT_W = 10;
   localparam logic [7:0] PTMR_OFF_CTRL_A = 8'h00;
   localparam logic [7:0] PTMR_OFF_CTRL_B = 8'h04;
   localparam logic [7:0] PTMR_OFF_CNT_LO = 8'h08;
   localparam logic [7:0] PTMR_OFF_CNT_HI = 8'h0C;
   localparam logic [7:0] PTMR_OFF_CMPA_LO = 8'h10;
   localparam logic [7:0] PTMR_OFF_CMPA_HI = 8'h14;
   localparam logic [7:0] PTMR_OFF_CMPP_LO = 8'h18;
   localparam logic [7:0] PTMR_OFF_CMPP_HI = 8'h1C;
   localparam logic [7:0] PTMR_OFF_STATUS = 8'h20;
   localparam logic [7:0] PTMR_CTRL_A_RST = 8'h00;
   localparam logic [7:0] PTMR_CTRL_B_RST = 8'h00;
   localparam logic [7:0] PTMR_CTRL_A_MASK = 8'hF8;
   localparam int PTMR_PAUSE_BIT = 7;
   localparam int PTMR_CKSEL_LSB = 4;
   localparam int PTMR_RUN_BIT = 3;
   localparam int PTMR_MODE_LSB = 6;
   localparam int PTMR_IOF_LSB = 4;
   localparam int PTMR_OLVL_BIT = 3;
   localparam int PTMR_INV_BIT = 2;
   localparam int PTMR_CAPS_BIT = 1;
   localparam int PTMR_CLRS_BIT = 0;
   localparam logic [1:0] PTMR_MODE_CMP = 2'h0;
   localparam logic [1:0] PTMR_MODE_CAP = 2'h1;
   localparam logic [1:0] PTMR_MODE_PWM = 2'h2;
   localparam logic [1:0] PTMR_MODE_TMR = 2'h3;
   localparam logic [2:0] PTMR_CK_SYS4 = 3'h0;
   localparam logic [2:0] PTMR_CK_SYS = 3'h1;
   localparam logic [2:0] PTMR_CK_H16 = 3'h2;
   localparam logic [2:0] PTMR_CK_H64 = 3'h3;
   localparam logic [2:0] PTMR_CK_TBC = 3'h4;
   localparam logic [2:0] PTMR_CK_H = 3'h5;
   localparam logic [2:0] PTMR_CK_EXTR = 3'h6;
   localparam logic [2:0] PTMR_CK_EXTF = 3'h7;
   localparam int PTMR_DIV_SYS = 4;
   localparam int PTMR_DIV_H16 = 16;
   localparam int PTMR_DIV_H64 = 64;
endpackage

// file: hdl/ptmr_edge.sv
// Two-flop synchroniser with rising and falling edge pulses for one pin
`timescale 1ns/1ps
module ptmr_edge (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Pin and edge pulses
   input wire logic pin,
   output logic rise,
   output logic fall
);
   import ptmr_pkg::*;
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } ptmr_edge_type;
   ptmr_edge_type st_q, st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = pin;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Edges come from the second and third flops only; the first may be metastable
   assign rise = st_q.s2 & ~st_q.s3;
   assign fall = ~st_q.s2 & st_q.s3;
endmodule

// file: hdl/ptmr_tick.sv
// Prescaler that turns a clock-rate strobe into ticks at a divided rate
`timescale 1ns/1ps
module ptmr_tick #(
   parameter int DIV = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Source strobe and divided tick
   input wire logic src,
   output logic tick
);
   import ptmr_pkg::*;
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   typedef struct packed {
      logic [CW-1:0] cnt;
   } ptmr_tick_type;
   ptmr_tick_type st_q, st_d;

   if (DIV < 1) begin : g_div_check
      $error("ptmr_tick: DIV must be at least 1");
   end

   always_comb begin
      st_d = st_q;
      if (src) begin
         st_d.cnt = (st_q.cnt == LAST) ? '0 : CW'(st_q.cnt + 1'b1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tick = src & (st_q.cnt == LAST);
endmodule

// file: test/ptmr_far_end.sv
// Far-side model: external clock pin source and capture pin driver
`timescale 1ns/1ps
module ptmr_far_end (
   // Clock
   input wire logic clk,
   // Pins driven toward the timer
   output logic ext_clk,
   output logic cap_in,
   // Timer pin seen from outside
   input wire logic pin_o,
   input wire logic pin_oe
);
   initial begin
      ext_clk = 1'b0;
      cap_in = 1'b0;
   end
   // Levels are held four cycles so the two-flop synchroniser never misses one
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (4) @(posedge clk);
         ext_clk <= 1'b1;
         repeat (4) @(posedge clk);
         ext_clk <= 1'b0;
      end
      repeat (6) @(posedge clk);
   endtask
   task automatic edge_in(input logic lvl);
      @(posedge clk);
      cap_in <= lvl;
      repeat (6) @(posedge clk);
   endtask
endmodule

// file: test/ptmr_bench.sv
// Self-checking bench for the periodic timer
`timescale 1ns/1ps
module ptmr_bench;
   import ptmr_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic high_stb = 1'b0;
   logic tbc_stb = 1'b0;
   logic hwrite = 1'b0;
   logic hsel = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic rd_dp = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, ext_clk, cap_in, pin_o, pin_oe, evt_a, evt_p, evt_c;
   int failures = 0;
   int num_checks = 0;
   int n_p = 0;
   int n_c = 0;
   int n_a = 0;
   logic [31:0] exp_q[$];
   string name_q[$];

   always #5 clk_sys = ~clk_sys;

   ptmr_top u_ptmr_top (.CLK_SYS(clk_sys), .RST_B(rst_b), .HIGH_CLK_STB(high_stb), .TBC_CLK_STB(tbc_stb),
      .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout),
      .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .EXT_CLOCK_PIN(ext_clk),
      .TIMER_IO_PIN_I(cap_in), .TIMER_IO_PIN_O(pin_o), .TIMER_IO_PIN_OE(pin_oe), .MATCH_A_EVT(evt_a),
      .MATCH_P_EVT(evt_p), .CAPTURE_EVT(evt_c));
   ptmr_far_end u_ptmr_far_end (.clk(clk_sys), .ext_clk(ext_clk), .cap_in(cap_in), .pin_o(pin_o),
      .pin_oe(pin_oe));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Reads queue their expectation; an empty name means the caller judges the data itself
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input string what,
                       output logic [31:0] rdat);
      hwrite <= wr;
      haddr <= {24'h00, a};
      htrans <= 2'h2;
      hsel <= 1'b1;
      hsize <= 3'h2;
      if (!wr) begin
         exp_q.push_back(d);
         name_q.push_back(what);
      end
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wr ? d : 32'h0;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rdat = hrdata;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, "", x);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string what);
      logic [31:0] x;
      xfer(1'b0, a, e, what, x);
   endtask
   // Restart keeps the chosen clock source but forces a run rising edge
   task automatic restart(input logic [7:0] ca);
      wreg(PTMR_OFF_CTRL_A, {24'h0, ca & 8'hF0});
      wreg(PTMR_OFF_CTRL_A, {24'h0, ca | 8'h08});
   endtask

   always @(posedge clk_sys) begin
      if (rd_dp && hreadyout === 1'b1 && exp_q.size() > 0) begin
         check("read response", {31'h0, hresp}, 32'h0);
         if (name_q[0] != "")
            check(name_q[0], hrdata, exp_q[0]);
         void'(exp_q.pop_front());
         void'(name_q.pop_front());
      end
      rd_dp <= htrans[1] & ~hwrite & hreadyout;
      if (evt_p === 1'b1)
         n_p++;
      if (evt_a === 1'b1)
         n_a++;
      if (evt_c === 1'b1)
         n_c++;
      high_stb <= 1'($urandom_range(1, 0));
      tbc_stb <= 1'($urandom_range(1, 0));
   end

   initial begin
      repeat (40000) @(posedge clk_sys);
      failures++;
      $display("Error watchdog expected finish seen hang");
      wrap_up();
   end

   initial begin
      logic [31:0] x;
      int n;
      void'($urandom(32'h16e7f782));
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++) rreg(8'(i * 4), 32'h0, "reset value");
      rreg(8'h40, 32'h0, "unmapped read");
      wreg(PTMR_OFF_CMPA_HI, 32'hFF);
      rreg(PTMR_OFF_CMPA_HI, 32'h03, "compare high bits");
      wreg(PTMR_OFF_CNT_LO, 32'hFF);
      rreg(PTMR_OFF_CNT_LO, 32'h00, "count not loadable");
      wreg(PTMR_OFF_CTRL_A, 32'h87);
      rreg(PTMR_OFF_CTRL_A, 32'h80, "control low bits zero");
      $display("test access done");
      wreg(PTMR_OFF_CTRL_B, 32'hC0);
      restart(8'h60);
      n = $urandom_range(40, 1);
      u_ptmr_far_end.pulses(n);
      rreg(PTMR_OFF_CNT_LO, 32'(n), "external rising count");
      wreg(PTMR_OFF_CTRL_A, 32'hE8);
      u_ptmr_far_end.pulses(3);
      wreg(PTMR_OFF_CTRL_A, 32'h68);
      u_ptmr_far_end.pulses(2);
      rreg(PTMR_OFF_CNT_LO, 32'(n + 2), "pause keeps count");
      wreg(PTMR_OFF_CTRL_A, 32'h60);
      u_ptmr_far_end.pulses(3);
      rreg(PTMR_OFF_CNT_LO, 32'(n + 2), "stopped keeps count");
      wreg(PTMR_OFF_CTRL_A, 32'h78);
      // The clear lands one edge after the run bit itself
      @(posedge clk_sys);
      rreg(PTMR_OFF_CNT_LO, 32'h0, "run rise clears");
      u_ptmr_far_end.pulses(4);
      rreg(PTMR_OFF_CNT_LO, 32'h4, "external falling count");
      $display("test counting done");
      wreg(PTMR_OFF_CMPP_LO, 32'h05);
      n_p = 0;
      restart(8'h60);
      u_ptmr_far_end.pulses(7);
      rreg(PTMR_OFF_CNT_LO, 32'h1, "clear on P match");
      check("P match events", 32'(n_p), 32'h1);
      wreg(PTMR_OFF_CTRL_B, 32'hC1);
      wreg(PTMR_OFF_CMPA_LO, 32'h03);
      wreg(PTMR_OFF_CMPA_HI, 32'h00);
      n_a = 0;
      restart(8'h60);
      u_ptmr_far_end.pulses(6);
      rreg(PTMR_OFF_CNT_LO, 32'h2, "clear on A match");
      check("A match events", 32'(n_a), 32'h1);
      wreg(PTMR_OFF_CTRL_B, 32'hC0);
      wreg(PTMR_OFF_CMPP_LO, 32'h00);
      restart(8'h60);
      u_ptmr_far_end.pulses(1023);
      rreg(PTMR_OFF_CNT_HI, 32'h3, "count high bits");
      rreg(PTMR_OFF_CNT_LO, 32'hFF, "count at maximum");
      u_ptmr_far_end.pulses(2);
      rreg(PTMR_OFF_CNT_LO, 32'h1, "wrap after overflow");
      $display("test clearing done");
      wreg(PTMR_OFF_CTRL_A, 32'h60);
      wreg(PTMR_OFF_CTRL_B, 32'h08);
      wreg(PTMR_OFF_CTRL_A, 32'h68);
      // Initial level is loaded one edge after the run bit
      @(posedge clk_sys);
      #1 check("pin enable compare", {31'h0, pin_oe}, 32'h1);
      check("pin initial level", {31'h0, pin_o}, 32'h1);
      wreg(PTMR_OFF_CTRL_B, 32'h0C);
      #1 check("pin inverted", {31'h0, pin_o}, 32'h0);
      wreg(PTMR_OFF_CTRL_A, 32'h60);
      wreg(PTMR_OFF_CTRL_B, 32'hCC);
      wreg(PTMR_OFF_CTRL_A, 32'h68);
      #1 check("pin released", {31'h0, pin_oe}, 32'h0);
      $display("test pin done");
      wreg(PTMR_OFF_CTRL_A, 32'h60);
      wreg(PTMR_OFF_CTRL_B, 32'h40);
      n_c = 0;
      wreg(PTMR_OFF_CTRL_A, 32'h68);
      n = $urandom_range(40, 1);
      u_ptmr_far_end.pulses(n);
      u_ptmr_far_end.edge_in(1'b1);
      rreg(PTMR_OFF_CMPA_LO, 32'(n), "capture rising");
      wreg(PTMR_OFF_CTRL_B, 32'h50);
      u_ptmr_far_end.pulses(2);
      u_ptmr_far_end.edge_in(1'b0);
      rreg(PTMR_OFF_CMPA_LO, 32'(n + 2), "capture falling");
      wreg(PTMR_OFF_CTRL_B, 32'h70);
      u_ptmr_far_end.pulses(1);
      u_ptmr_far_end.edge_in(1'b1);
      u_ptmr_far_end.edge_in(1'b0);
      rreg(PTMR_OFF_CMPA_LO, 32'(n + 2), "capture disabled");
      wreg(PTMR_OFF_CTRL_B, 32'h60);
      u_ptmr_far_end.edge_in(1'b1);
      rreg(PTMR_OFF_CMPA_LO, 32'(n + 3), "capture both edges");
      // Clock pin as trigger: rise captures before its own tick, fall after it
      wreg(PTMR_OFF_CTRL_B, 32'h62);
      u_ptmr_far_end.pulses(1);
      rreg(PTMR_OFF_CMPA_LO, 32'(n + 4), "capture from clock pin");
      check("capture events", 32'(n_c), 32'h5);
      $display("test capture done");
      wreg(PTMR_OFF_CTRL_A, 32'h60);
      wreg(PTMR_OFF_CTRL_B, 32'hC0);
      for (int c = 0; c < 6; c++) begin
         restart(8'(c << 4));
         repeat (200) @(posedge clk_sys);
         xfer(1'b0, PTMR_OFF_CNT_LO, 32'h0, "", x);
         check("internal clock advances", {31'h0, x != 32'h0}, 32'h1);
      end
      $display("test internal clocks done");
      wrap_up();
   end
endmodule
